// ---- rtl/fasp_cfg.svh ----
`ifndef FASP_CFG_SVH
`define FASP_CFG_SVH
// register byte offsets
`define FASP_OFF_CTRL      12'h000
`define FASP_OFF_CMD       12'h004
`define FASP_OFF_ADDR      12'h008
`define FASP_OFF_PROT      12'h00C
`define FASP_OFF_STATUS    12'h010
`define FASP_OFF_RESULT    12'h014
`define FASP_OFF_DECODE    12'h018
`define FASP_OFF_UID_LO    12'h01C
`define FASP_OFF_UID_HI    12'h020
// ctrl fields
`define FASP_CTRL_EXT_BIT  0
`define FASP_CTRL_EXT_NV   1
`define FASP_CTRL_BIG      2
// config one nonvolatile: region lock field
`define FASP_CFG_LOCK_HI   5
`define FASP_CFG_LOCK_LO   2
// protect register fields
`define FASP_IRP_PWD_BIT   2
`define FASP_IRP_RD_BIT    6
`define FASP_PROT_TMP_BIT  8
`define FASP_PROT_PASS_BIT 9
// status two volatile error bits
`define FASP_ST_PERR_BIT   6
`define FASP_ST_EERR_BIT   5
// command codes
`define FASP_OP_ID_READ    8'h9F
`define FASP_OP_PARAM_READ 8'h5A
`define FASP_OP_SEC_READ   8'h48
`define FASP_OP_SEC_PROG   8'h42
`define FASP_OP_SEC_ERASE  8'h44
`define FASP_OP_MAIN_READ  8'h03
`define FASP_OP_MAIN_PROG  8'h02
`define FASP_OP_SEC4K      8'h20
`define FASP_OP_HBLK       8'h52
`define FASP_OP_BLK        8'hD8
`define FASP_OP_READ4      8'h13
`define FASP_OP_PROG4      8'h12
// space sizes
`define FASP_SEC_SPACE_MSK 32'h0000_03FF
`define FASP_BIG_MSK       32'h01FF_FFFF
`define FASP_SMALL_MSK     32'h00FF_FFFF
`define FASP_LOW24_MSK     32'h00FF_FFFF
`define FASP_ERASED_BYTE   8'hFF
`endif

// ---- rtl/fasp_pkg.sv ----
package fasp_pkg;
    typedef enum logic [2:0] {
        FASP_IDLE = 3'b001,
        FASP_EXEC = 3'b010,
        FASP_DONE = 3'b100
    } fasp_state_t;

    typedef enum logic [2:0] {
        FASP_SP_MAIN  = 3'h0,
        FASP_SP_ID    = 3'h1,
        FASP_SP_PARAM = 3'h2,
        FASP_SP_SEC   = 3'h3,
        FASP_SP_NONE  = 3'h4
    } fasp_space_t;
endpackage : fasp_pkg

// ---- rtl/fasp_sec_mem.sv ----
`timescale 1ns/1ns
`include "fasp_cfg.svh"
// security space storage; registered read data, erase sets a 256 byte region to erased
module fasp_sec_mem #(
    parameter int AW = 10
) (
    input  wire logic          core_clk,
    input  wire logic          we,
    input  wire logic          erase,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [0:(1<<AW)-1];
    logic [AW-9:0] ereg;

    // region select needs at least address bit 8
    if (AW < 9) begin : g_aw_chk
        $error("fasp_sec_mem: AW too small");
    end

    assign ereg = waddr[AW-1:8];

    // write port, erase fills one region with erased bytes
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < (1<<AW); i++) begin
            if (erase && (i[AW-1:8] == ereg)) begin
                mem[i] <= `FASP_ERASED_BYTE;
            end
        end
        if (we) begin
            mem[waddr] <= mem[waddr] & wdata; // flash program only clears bits
        end
        rdata <= mem[raddr];
    end
endmodule : fasp_sec_mem

// ---- rtl/fasp_top.sv ----
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "fasp_cfg.svh"
//
// How it works
// - extended mode makes legacy commands use 32 bits
// - extended mode off: 24-bit address, low 16MB
// - four-byte commands always use 32 bits
// - reset loads extended mode from nonvolatile bit
// - 64K blocks, 32K halves, 4K sectors, aligned
// - big variant decodes to 1FFFFFFh
// - small variant decodes to FFFFFFh
// - id read hits separate read-only space
// - id space holds 64-bit unique number
// - parameter read hits separate read-only space
// - parameter space contains the id table
// - 1024-byte security space, four 256-byte regions
// - regions consecutive, 000 through 3FF
// - unlocked regions programmable and erasable
// - erased security bytes read FFh
// - OTP lock bits 5:2 block program/erase
// - temporary lock blocks regions two, three
// - temporary lock changed only by protection logic
// - password bit blocks regions two, three
// - read protect bit blocks region three reads
// - protected read returns invalid data
// - blocked write leaves data, sets error bits
// - partial-byte program/erase ignored, no error
module fasp_top
    import fasp_pkg::*;
#(
    parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF, // arbitrary value
    parameter logic [31:0] PARAM_SIG = 32'h5044_4653            // arbitrary value
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        ext_nv,
    input  wire logic        big_variant,
    input  wire logic [3:0]  region_lock_nv,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef struct packed {
        fasp_state_t st;
        logic        strap_done;
        logic        ext_mode;
        logic [3:0]  lock;
        logic [7:0]  individual_region_protect_register;
        logic        tmp_lock;
        logic        pass_ok;
        logic        perr;
        logic        eerr;
        logic [7:0]  op;
        logic [7:0]  wbyte;
        logic [5:0]  bits;
        logic [31:0] addr;
        logic [31:0] eff;
        fasp_space_t space;
        logic [7:0]  result;
        logic        have_aw;
        logic        have_w;
        logic [11:0] awa;
        logic [31:0] wd;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        rd_pend;
    } fasp_state_reg_t;

    fasp_state_reg_t q;
    fasp_state_reg_t next_q;
    logic            mem_we;
    logic            mem_erase;
    logic [7:0]      mem_rdata;
    logic [31:0]     amask;
    logic            four_byte_op;
    logic            is_prog;
    logic            is_erase;
    logic [1:0]      region;
    logic            region_blocked;
    logic            read_blocked;
    logic [7:0]      id_byte;
    logic [7:0]      param_byte;
    logic [11:0]     ara;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers
    assign four_byte_op = (q.op == `FASP_OP_READ4) || (q.op == `FASP_OP_PROG4);
    assign amask = q.ext_mode || four_byte_op ?
                   (big_variant ? `FASP_BIG_MSK : `FASP_SMALL_MSK) :
                   `FASP_LOW24_MSK;
    assign is_prog  = (q.op == `FASP_OP_SEC_PROG) || (q.op == `FASP_OP_MAIN_PROG) ||
                      (q.op == `FASP_OP_PROG4);
    assign is_erase = (q.op == `FASP_OP_SEC_ERASE) || (q.op == `FASP_OP_SEC4K) ||
                      (q.op == `FASP_OP_HBLK) || (q.op == `FASP_OP_BLK);
    assign region = q.addr[9:8];
    // otp lock, temporary lock and password each guard their regions
    assign region_blocked = q.lock[region] ||
                            (region[1] && q.tmp_lock) ||
                            (region[1] && q.individual_region_protect_register[`FASP_IRP_PWD_BIT] && !q.pass_ok);
    assign read_blocked = (region == 2'h3) && q.individual_region_protect_register[`FASP_IRP_RD_BIT] && !q.pass_ok;

    // id table bytes: unique number in the first eight
    always_comb begin
        id_byte = 8'h00;
        if (q.addr[7:3] == 5'h00) begin
            id_byte = UNIQUE_ID[{q.addr[2:0], 3'h0} +: 8];
        end
    end

    // parameter table: signature header then the id table at 10h
    always_comb begin
        param_byte = 8'h00;
        if (q.addr[7:2] == 6'h00) begin
            param_byte = PARAM_SIG[{q.addr[1:0], 3'h0} +: 8];
        end else if (q.addr[7:4] == 4'h1) begin
            param_byte = (q.addr[3] == 1'b0) ? UNIQUE_ID[{q.addr[2:0], 3'h0} +: 8] :
                         8'h00;
        end
    end

    assign mem_we    = (q.st == FASP_EXEC) && (q.space == FASP_SP_SEC) && is_prog &&
                       !region_blocked && (q.bits == 6'h00);
    assign mem_erase = (q.st == FASP_EXEC) && (q.space == FASP_SP_SEC) && is_erase &&
                       !region_blocked && (q.bits == 6'h00);

    fasp_sec_mem #(
        .AW(10)
    ) u_sec (
        .core_clk(core_clk),
        .we      (mem_we),
        .erase   (mem_erase),
        .waddr   (q.addr[9:0]),
        .wdata   (q.wbyte),
        .raddr   (q.addr[9:0]),
        .rdata   (mem_rdata)
    );

    assign ara = s_axi_araddr[11:0];

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_q = q;
        // reset defaults caught after release
        if (!q.strap_done) begin
            next_q.strap_done = 1'b1;
            next_q.ext_mode   = ext_nv;
            next_q.lock       = region_lock_nv;
        end
        // command execution
        case (q.st)
            FASP_IDLE: begin
            end
            FASP_EXEC: begin
                next_q.st = FASP_DONE;
                if (q.bits != 6'h00 && (is_prog || is_erase)) begin
                    next_q.st = FASP_IDLE;
                end else begin
                    case (q.space)
                        FASP_SP_SEC: begin
                            if ((is_prog || is_erase) && region_blocked) begin
                                next_q.perr = q.perr | is_prog;
                                next_q.eerr = q.eerr | is_erase;
                            end
                        end
                        FASP_SP_ID, FASP_SP_PARAM: begin
                            next_q.perr = q.perr | is_prog;
                            next_q.eerr = q.eerr | is_erase;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            FASP_DONE: begin
                next_q.st = FASP_IDLE;
                case (q.space)
                    FASP_SP_ID:    next_q.result = id_byte;
                    FASP_SP_PARAM: next_q.result = param_byte;
                    FASP_SP_SEC:   next_q.result = read_blocked ? 8'h00 : mem_rdata;
                    default:       next_q.result = 8'h00;
                endcase
            end
            default: next_q.st = FASP_IDLE;
        endcase
        // axi write
        if (s_axi_awvalid && !q.have_aw) begin
            next_q.have_aw = 1'b1;
            next_q.awa     = s_axi_awaddr[11:0];
        end
        if (s_axi_wvalid && !q.have_w) begin
            next_q.have_w = 1'b1;
            next_q.wd     = s_axi_wdata;
        end
        if (q.have_aw && q.have_w && !q.bvalid) begin
            next_q.have_aw = 1'b0;
            next_q.have_w  = 1'b0;
            next_q.bvalid  = 1'b1;
            next_q.bresp   = 2'b00;
            case (q.awa)
                `FASP_OFF_CTRL: begin
                    next_q.ext_mode = q.wd[`FASP_CTRL_EXT_BIT];
                end
                `FASP_OFF_CMD: begin
                    if (q.st == FASP_IDLE) begin
                        next_q.st    = FASP_EXEC;
                        next_q.op    = q.wd[7:0];
                        next_q.wbyte = q.wd[15:8];
                        next_q.bits  = q.wd[21:16];
                    end
                end
                `FASP_OFF_ADDR: begin
                    next_q.addr = q.wd;
                end
                `FASP_OFF_PROT: begin
                    next_q.individual_region_protect_register      = q.wd[7:0];
                    next_q.tmp_lock = q.wd[`FASP_PROT_TMP_BIT];
                    next_q.pass_ok  = q.wd[`FASP_PROT_PASS_BIT];
                    next_q.lock     = q.lock | q.wd[`FASP_CFG_LOCK_HI+8:`FASP_CFG_LOCK_LO+8];
                end
                `FASP_OFF_STATUS: begin
                    // write one clears; a same-cycle blocked security set wins below
                    next_q.perr = q.perr & ~q.wd[`FASP_ST_PERR_BIT];
                    next_q.eerr = q.eerr & ~q.wd[`FASP_ST_EERR_BIT];
                end
                default: next_q.bresp = 2'b10;
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            next_q.bvalid = 1'b0;
        end
        // address masking and space routing when a command starts
        if (q.st == FASP_IDLE && next_q.st == FASP_EXEC) begin
            case (next_q.op)
                `FASP_OP_ID_READ:    next_q.space = FASP_SP_ID;
                `FASP_OP_PARAM_READ: next_q.space = FASP_SP_PARAM;
                `FASP_OP_SEC_READ, `FASP_OP_SEC_PROG, `FASP_OP_SEC_ERASE: begin
                    next_q.space = FASP_SP_SEC;
                    next_q.addr  = next_q.addr & `FASP_SEC_SPACE_MSK;
                end
                default:             next_q.space = FASP_SP_MAIN;
            endcase
        end
        if (q.st == FASP_EXEC && q.space == FASP_SP_MAIN) begin
            next_q.eff = q.addr & amask;
            case (q.op)
                `FASP_OP_SEC4K: next_q.eff = q.addr & amask & 32'hFFFF_F000;
                `FASP_OP_HBLK:  next_q.eff = q.addr & amask & 32'hFFFF_8000;
                `FASP_OP_BLK:   next_q.eff = q.addr & amask & 32'hFFFF_0000;
                default: begin
                end
            endcase
        end
        // security space error sets win over a software clear
        if (q.st == FASP_EXEC && q.bits == 6'h00) begin
            if (q.space == FASP_SP_SEC && region_blocked) begin
                next_q.perr = next_q.perr | is_prog;
                next_q.eerr = next_q.eerr | is_erase;
            end
        end
        // axi read
        if (s_axi_arvalid && !q.rvalid) begin
            next_q.rvalid = 1'b1;
            next_q.rresp  = 2'b00;
            case (ara)
                `FASP_OFF_CTRL:   next_q.rdata = {29'h0, big_variant, ext_nv, q.ext_mode};
                `FASP_OFF_CMD:    next_q.rdata = {q.st != FASP_IDLE, 9'h0, q.bits, q.wbyte,
                                                  q.op};
                `FASP_OFF_ADDR:   next_q.rdata = q.addr;
                `FASP_OFF_PROT:   next_q.rdata = {18'h0, q.lock, q.pass_ok, q.tmp_lock,
                                                  q.individual_region_protect_register};
                `FASP_OFF_STATUS: next_q.rdata = {25'h0, q.perr, q.eerr, 5'h0};
                `FASP_OFF_RESULT: next_q.rdata = {24'h0, q.result};
                `FASP_OFF_DECODE: next_q.rdata = q.eff;
                `FASP_OFF_UID_LO: next_q.rdata = UNIQUE_ID[31:0];
                `FASP_OFF_UID_HI: next_q.rdata = UNIQUE_ID[63:32];
                default: begin
                    next_q.rdata = 32'h0;
                    next_q.rresp = 2'b10;
                end
            endcase
        end
        if (q.rvalid && s_axi_rready) begin
            next_q.rvalid = 1'b0;
        end
        next_q.rd_pend = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q    <= '0;
            q.st <= FASP_IDLE;
        end else begin
            q <= next_q;
        end
    end

    // bus handshakes
    assign s_axi_awready = !q.have_aw;
    assign s_axi_wready  = !q.have_w;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rresp   = q.rresp;
    assign s_axi_rdata   = q.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence blocked_write_s;
        q.st == FASP_EXEC && q.space == FASP_SP_SEC && is_prog && region_blocked &&
        q.bits == 6'h00;
    endsequence

    blocked_prog_a: assert property (@(posedge core_clk) disable iff (!nrst)
        blocked_write_s |=> q.perr)
        else $error("blocked program did not set error");
    no_write_blocked_a: assert property (@(posedge core_clk) disable iff (!nrst)
        region_blocked |-> !mem_we && !mem_erase)
        else $error("write reached blocked region");
    partial_ignored_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (q.st == FASP_EXEC && q.bits != 6'h00 && (is_prog || is_erase) && !q.perr)
        |=> !q.perr)
        else $error("partial byte command raised error");
    read_hidden_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (q.st == FASP_DONE && q.space == FASP_SP_SEC && read_blocked) |=> q.result == 8'h00)
        else $error("protected region read leaked data");
    mask_24_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (!q.ext_mode && !four_byte_op) |-> amask == `FASP_LOW24_MSK)
        else $error("24-bit mask wrong");
    mask_four_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (four_byte_op && big_variant) |-> amask == `FASP_BIG_MSK)
        else $error("four-byte command not 32-bit");
    strap_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !q.strap_done |=> q.ext_mode == $past(ext_nv))
        else $error("extended mode not loaded");
    block_align_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (q.st == FASP_EXEC && q.space == FASP_SP_MAIN && q.op == `FASP_OP_BLK)
        |=> q.eff[15:0] == 16'h0000)
        else $error("block erase not aligned");
    bresp_once_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (q.bvalid && !s_axi_bready) |=> q.bvalid)
        else $error("write response dropped");
    tmp_lock_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $changed(q.tmp_lock) |-> $past(q.awa == `FASP_OFF_PROT && q.have_aw && q.have_w))
        else $error("temporary lock changed outside protect write");
endmodule : fasp_top

// ---- verif/fasp_host.sv ----
`timescale 1ns/1ns
// axi4-lite master standing in for the host controller
module fasp_host (
    input  wire logic        core_clk,
    output logic [31:0]      awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [31:0]      araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    ////////////////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        {awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
        {bready, rready, wstrb} = 6'h3F; // answers are always taken
    end

    // one write; released payload shows the inverse so stale data never looks valid
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic ad, wd, bd;
        {ad, wd, bd} = 3'h0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!bd) begin
            @(posedge core_clk);
            if (!ad && awvalid && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (!wd && wvalid && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (ad && wd && bvalid && bready) begin
                bd = 1'b1;
                resp = bresp;
            end
        end
    endtask : wr

    // one read; data and response taken at the edge where rvalid is seen
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ad, rd_done;
        {ad, rd_done} = 2'h0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!rd_done) begin
            @(posedge core_clk);
            if (!ad && arvalid && arready) begin
                ad = 1'b1;
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (ad && rvalid && rready) begin
                rd_done = 1'b1;
                d = rdata;
                resp = rresp;
            end
        end
    endtask : rd
endmodule : fasp_host

// ---- verif/test_flash_address_space_protection.sv ----
`timescale 1ns/1ns
`include "fasp_cfg.svh"
module test_flash_address_space_protection
    import fasp_pkg::*;
;
    typedef struct packed {
        logic        ext;
        logic        big;
        logic [7:0]  op;
        logic [31:0] a;
        logic [31:0] exp;
    } fasp_row_t;

    localparam logic [63:0] UID = 64'hA5C3_0F1E_7B29_D486; // arbitrary value

    logic        core_clk, nrst, ext_nv, big_variant;
    logic [3:0]  region_lock_nv;
    logic [31:0] awaddr, wdata, araddr, rdata, v;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          error_cnt, checks_done, cyc;
    fasp_row_t   rows [7];

    fasp_top #(.UNIQUE_ID(UID)) i_fasp_top (
        .core_clk(core_clk), .nrst(nrst), .ext_nv(ext_nv), .big_variant(big_variant),
        .region_lock_nv(region_lock_nv), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    fasp_host i_fasp_host (
        .core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic stop_test();
        if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [11:0] off, input logic [31:0] d);
        i_fasp_host.wr({20'h00000, off}, d, resp);
    endtask : wr

    task automatic rd(input logic [11:0] off, output logic [31:0] d);
        i_fasp_host.rd({20'h00000, off}, d, resp);
    endtask : rd

    // issue a command and poll busy under a bound
    task automatic cmd(input logic [7:0] op, input logic [31:0] a, input logic [7:0] d,
                       input logic [5:0] left);
        logic [31:0] r;
        int n;
        wr(`FASP_OFF_ADDR, a);
        wr(`FASP_OFF_CMD, {10'h000, left, d, op});
        r = 32'h8000_0000;
        n = 0;
        while (r[31] !== 1'b0 && n < 50) begin
            rd(`FASP_OFF_CMD, r);
            n++;
        end
        chk("busy", {31'h0, r[31]}, 32'h0);
    endtask : cmd

    task automatic sec_chk(input logic [31:0] a, input logic [7:0] e,
                           input logic [7:0] op = `FASP_OP_SEC_READ);
        cmd(op, a, 8'h00, 6'h00);
        rd(`FASP_OFF_RESULT, v);
        chk("sec_byte", {24'h0, v[7:0]}, {24'h0, e});
    endtask : sec_chk

    // error flags, then write one to clear
    task automatic st_chk(input logic [1:0] e);
        rd(`FASP_OFF_STATUS, v);
        chk("status", {30'h0, v[6:5]}, {30'h0, e});
        wr(`FASP_OFF_STATUS, 32'h0000_0060);
    endtask : st_chk

    task automatic do_reset(input logic ext, input logic [3:0] lock);
        nrst <= 1'b0;
        ext_nv <= ext;
        region_lock_nv <= lock;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {nrst, ext_nv, big_variant, region_lock_nv, error_cnt, checks_done, cyc} = '0;
        big_variant = 1'b1;
        rows[0] = '{1'b0, 1'b1, 8'h03, 32'h0123_4567, 32'h0023_4567};
        rows[1] = '{1'b1, 1'b1, 8'h03, 32'h0123_4567, 32'h0123_4567};
        rows[2] = '{1'b0, 1'b1, 8'h13, 32'h0123_4567, 32'h0123_4567};
        rows[3] = '{1'b1, 1'b0, 8'h13, 32'hFF23_4567, 32'h0023_4567};
        rows[4] = '{1'b1, 1'b1, 8'h20, 32'h01FF_FFFF, 32'h01FF_F000};
        rows[5] = '{1'b1, 1'b1, 8'h52, 32'h0000_FFFF, 32'h0000_8000};
        rows[6] = '{1'b1, 1'b1, 8'hD8, 32'h01FF_FFFF, 32'h01FF_0000};
        do_reset(1'b1, 4'h0);
        rd(`FASP_OFF_CTRL, v);
        chk("ctrl", {29'h0, v[2:0]}, 32'h7);
        rd(`FASP_OFF_UID_LO, v);
        chk("uid_lo", v, UID[31:0]);
        rd(`FASP_OFF_UID_HI, v);
        chk("uid_hi", v, UID[63:32]);
        sec_chk(32'h0000_0003, UID[31:24], `FASP_OP_ID_READ);
        sec_chk(32'h0000_0013, UID[31:24], `FASP_OP_PARAM_READ);
        i_fasp_host.rd(32'h0000_00FC, v, resp);
        chk("unmapped", {30'h0, resp}, 32'h2);
        // address decode table
        foreach (rows[i]) begin
            big_variant <= rows[i].big;
            wr(`FASP_OFF_CTRL, {31'h0, rows[i].ext});
            cmd(rows[i].op, rows[i].a, 8'h00, 6'h00);
            rd(`FASP_OFF_DECODE, v);
            chk("decode", v, rows[i].exp);
        end
        big_variant <= 1'b1;
        // erase, program and aliasing of the security space
        cmd(`FASP_OP_SEC_ERASE, 32'h0000_0000, 8'h00, 6'h00);
        cmd(`FASP_OP_SEC_ERASE, 32'h0000_0100, 8'h00, 6'h00);
        cmd(`FASP_OP_SEC_ERASE, 32'h0000_0300, 8'h00, 6'h00);
        sec_chk(32'h0000_00FF, 8'hFF);
        sec_chk(32'h0000_07FF, 8'hFF);
        cmd(`FASP_OP_SEC_PROG, 32'h0000_0010, 8'h5A, 6'h00);
        sec_chk(32'h0000_0010, 8'h5A);
        cmd(`FASP_OP_SEC_PROG, 32'h0000_0010, 8'h0F, 6'h00);
        sec_chk(32'h0000_0010, 8'h0A);
        sec_chk(32'h0000_0110, 8'hFF);
        // partial byte program is dropped silently
        cmd(`FASP_OP_SEC_PROG, 32'h0000_0010, 8'h00, 6'h03);
        sec_chk(32'h0000_0010, 8'h0A);
        st_chk(2'b00);
        // temporary lock on region two
        wr(`FASP_OFF_PROT, 32'h0000_0100);
        cmd(`FASP_OP_SEC_ERASE, 32'h0000_0200, 8'h00, 6'h00);
        st_chk(2'b01);
        wr(`FASP_OFF_PROT, 32'h0000_0000);
        cmd(`FASP_OP_SEC_ERASE, 32'h0000_0200, 8'h00, 6'h00);
        st_chk(2'b00);
        sec_chk(32'h0000_0200, 8'hFF);
        // password and read protection of region three
        wr(`FASP_OFF_PROT, 32'h0000_0044);
        cmd(`FASP_OP_SEC_PROG, 32'h0000_0300, 8'h12, 6'h00);
        st_chk(2'b10);
        sec_chk(32'h0000_0300, 8'h00);
        wr(`FASP_OFF_PROT, 32'h0000_0244);
        sec_chk(32'h0000_0300, 8'hFF);
        cmd(`FASP_OP_SEC_PROG, 32'h0000_0300, 8'h12, 6'h00);
        sec_chk(32'h0000_0300, 8'h12);
        // one-time lock of region zero cannot be undone
        wr(`FASP_OFF_PROT, 32'h0000_0400);
        cmd(`FASP_OP_SEC_ERASE, 32'h0000_0000, 8'h00, 6'h00);
        st_chk(2'b01);
        sec_chk(32'h0000_0010, 8'h0A);
        wr(`FASP_OFF_PROT, 32'h0000_0000);
        rd(`FASP_OFF_PROT, v);
        chk("otp_lock", {28'h0, v[13:10]}, 32'h1);
        // second reset loads new defaults
        do_reset(1'b0, 4'h2);
        rd(`FASP_OFF_CTRL, v);
        chk("ctrl", {29'h0, v[2:0]}, 32'h4);
        cmd(`FASP_OP_SEC_PROG, 32'h0000_0150, 8'h00, 6'h00);
        st_chk(2'b10);
        stop_test();
    end
endmodule : test_flash_address_space_protection
